// >>> logic/alarm_pkg.sv
// constants, offsets and types shared by the alarm and clock upset monitor
//
// Behaviour
// - Four alarm events are watched: serializer PLL out of lock, link out of data state, sysref realign, clock upset.
// - Each alarm event sets its own bit in the alarm status register.
// - A status bit stays set after its cause is gone until the host writes a one to that bit.
// - Status bits whose type is not masked feed the summary alarm register; masked ones do not.
// - When the pin select bit chooses alarm mode the status output pin goes high on an unmasked alarm.
// - With the link enabled and both channels powered up, channel A and B clocks are compared every cycle; any difference sets the clock upset flag.
// - The clock upset flag stays set until the host writes a one to it.
// - While the link enable is zero the link logic is held in reset, serializers powered down, clocks gated.
package alarm_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int ALARM_N = 4;
    localparam int ALM_PLL_UNLOCK = 0;
    localparam int ALM_LINK_IDLE = 1;
    localparam int ALM_SYSREF_REALIGN = 2;
    localparam int ALM_CLOCK_UPSET = 3;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CLEAR = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SUMMARY = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h14;
    localparam int CFG_W = 4;
    localparam int CFG_LINK_EN = 0;
    localparam int CFG_PIN_ALARM = 1;
    localparam int CFG_PD_A = 2;
    localparam int CFG_PD_B = 3;
    localparam logic [ALARM_N-1:0] STATUS_RESET = 4'h0;
    localparam logic [ALARM_N-1:0] MASK_RESET = 4'h0;
    localparam logic [ALARM_N-1:0] IRQ_EN_RESET = 4'h0;
    localparam logic [CFG_W-1:0] CONFIG_RESET = 4'h0;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

    typedef enum {BUS_SETUP, BUS_ANSWER} bus_phase_t;

    function automatic logic addr_is(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
        return addr == ofs;
    endfunction
endpackage

// >>> logic/upset_if.sv
// signals between the monitor core and the channel clock comparator
interface upset_if #(parameter int CLOCK_W = 4);
    logic enable;
    logic both_on;
    logic [CLOCK_W-1:0] clocks_a;
    logic [CLOCK_W-1:0] clocks_b;
    logic upset;

    modport monitor (input enable, input both_on, input clocks_a, input clocks_b, output upset);
    modport owner (output enable, output both_on, output clocks_a, output clocks_b, input upset);
endinterface

// >>> logic/clock_compare.sv
// channel A against channel B internal clock comparator
module clock_compare #(
    parameter int CLOCK_W = 4
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    upset_if.monitor bus
);
    logic upset_q;
    logic upset_d;

    if (CLOCK_W < 1) begin : g_bad_width
        $error("clock_compare needs CLOCK_W of at least 1");
    end

    // link enable low acts as a reset of this section
    always_comb begin
        upset_d = bus.enable && bus.both_on && (bus.clocks_a != bus.clocks_b);
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            upset_q <= 1'b0;
        end else begin
            upset_q <= upset_d;
        end
    end

    assign bus.upset = upset_q;

    property p_mismatch_seen;
        @(posedge i_clock) disable iff (!i_rst_n)
        (bus.enable && bus.both_on && bus.clocks_a != bus.clocks_b) |=> bus.upset;
    endproperty
    a_mismatch_seen: assert property (p_mismatch_seen) else $error("clock mismatch not reported");
endmodule

// >>> logic/alarm_monitor.sv
// alarm and clock upset monitor with apb register access
//
// Design decisions made here: the APB register port and the register addresses.
module alarm_monitor import alarm_pkg::*; #(
    parameter int CLOCK_W = 4
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [DATA_W-1:0] i_pwdata,
    output logic [DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_pll_locked,
    input wire logic i_link_in_data,
    input wire logic i_sysref_realign,
    input wire logic [CLOCK_W-1:0] i_clocks_a,
    input wire logic [CLOCK_W-1:0] i_clocks_b,
    input wire logic i_cal_status,
    output logic o_irq,
    output logic o_status_output_pin,
    output logic o_serial_link_enable,
    output logic o_link_rst_n,
    output logic o_serializer_pd,
    output logic o_link_clock_en,
    output logic o_channel_a_powerdown,
    output logic o_channel_b_powerdown
);
    logic [1:0] rst_sync_q;
    logic rst_n;

    bus_phase_t phase_q;
    bus_phase_t phase_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [DATA_W-1:0] prdata_q;
    logic [DATA_W-1:0] prdata_d;
    logic mapped;
    logic [DATA_W-1:0] read_word;
    logic wr_commit;

    logic [ALARM_N-1:0] status_q;
    logic [ALARM_N-1:0] status_d;
    logic [ALARM_N-1:0] mask_q;
    logic [ALARM_N-1:0] mask_d;
    logic [ALARM_N-1:0] irq_en_q;
    logic [ALARM_N-1:0] irq_en_d;
    logic [CFG_W-1:0] cfg_q;
    logic [CFG_W-1:0] cfg_d;
    logic [ALARM_N-1:0] events;
    logic [ALARM_N-1:0] clr;
    logic [ALARM_N-1:0] kept;
    logic any_unmasked;

    logic alarm_sum_q;
    logic alarm_sum_d;
    logic irq_q;
    logic irq_d;
    logic pin_q;
    logic pin_d;
    logic ser_pd_q;
    logic ser_pd_d;

    upset_if #(.CLOCK_W(CLOCK_W)) upset_bus ();

    if (CLOCK_W < 1) begin : g_bad_width
        $error("alarm_monitor needs CLOCK_W of at least 1");
    end

    // reset released through two flops so every flop leaves reset on one edge
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ---- apb slave, one wait state on every access
    always_comb begin
        mapped = addr_is(i_paddr, OFS_STATUS) || addr_is(i_paddr, OFS_CLEAR)
            || addr_is(i_paddr, OFS_MASK) || addr_is(i_paddr, OFS_SUMMARY)
            || addr_is(i_paddr, OFS_IRQ_EN) || addr_is(i_paddr, OFS_CONFIG);
        read_word = READ_ZERO;
        if (addr_is(i_paddr, OFS_STATUS)) begin
            read_word = DATA_W'(status_q);
        end else if (addr_is(i_paddr, OFS_MASK)) begin
            read_word = DATA_W'(mask_q);
        end else if (addr_is(i_paddr, OFS_SUMMARY)) begin
            read_word = DATA_W'(alarm_sum_q);
        end else if (addr_is(i_paddr, OFS_IRQ_EN)) begin
            read_word = DATA_W'(irq_en_q);
        end else if (addr_is(i_paddr, OFS_CONFIG)) begin
            read_word = DATA_W'(cfg_q);
        end
    end

    always_comb begin
        phase_d = phase_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        unique case (phase_q)
            BUS_SETUP: begin
                if (i_psel && i_penable) begin
                    phase_d = BUS_ANSWER;
                    pready_d = 1'b1;
                    pslverr_d = !mapped;
                    prdata_d = i_pwrite ? READ_ZERO : read_word;
                end
            end
            BUS_ANSWER: begin
                phase_d = BUS_SETUP;
            end
        endcase
    end

    // the write lands on the edge that also completes the transfer
    assign wr_commit = (phase_q == BUS_ANSWER) && i_psel && i_penable && i_pwrite && !pslverr_q;

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= BUS_SETUP;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= READ_ZERO;
        end else begin
            phase_q <= phase_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // ---- alarm sources
    assign upset_bus.enable = cfg_q[CFG_LINK_EN];
    assign upset_bus.both_on = !cfg_q[CFG_PD_A] && !cfg_q[CFG_PD_B];
    assign upset_bus.clocks_a = i_clocks_a;
    assign upset_bus.clocks_b = i_clocks_b;

    clock_compare #(.CLOCK_W(CLOCK_W)) u_compare (
        .i_clock(i_clock),
        .i_rst_n(rst_n),
        .bus(upset_bus)
    );

    // pll and link state mean nothing while the serializers are powered down
    always_comb begin
        events = '0;
        events[ALM_PLL_UNLOCK] = cfg_q[CFG_LINK_EN] && !i_pll_locked;
        events[ALM_LINK_IDLE] = cfg_q[CFG_LINK_EN] && !i_link_in_data;
        events[ALM_SYSREF_REALIGN] = i_sysref_realign;
        events[ALM_CLOCK_UPSET] = upset_bus.upset;
    end

    // status may be cleared at its own offset or through the write-only clear word
    assign clr = (wr_commit && (addr_is(i_paddr, OFS_STATUS) || addr_is(i_paddr, OFS_CLEAR)))
        ? i_pwdata[ALARM_N-1:0] : '0;

    for (genvar i = 0; i < ALARM_N; i++) begin : g_sticky
        // set beats clear, zero bits of the write leave the flag as is
        assign status_d[i] = events[i] || (status_q[i] && !clr[i]);
        assign kept[i] = status_q[i] && !clr[i];
    end

    always_comb begin
        mask_d = mask_q;
        irq_en_d = irq_en_q;
        cfg_d = cfg_q;
        if (wr_commit && addr_is(i_paddr, OFS_MASK)) begin
            mask_d = i_pwdata[ALARM_N-1:0];
        end
        if (wr_commit && addr_is(i_paddr, OFS_IRQ_EN)) begin
            irq_en_d = i_pwdata[ALARM_N-1:0];
        end
        if (wr_commit && addr_is(i_paddr, OFS_CONFIG)) begin
            cfg_d = i_pwdata[CFG_W-1:0];
        end
    end

    assign any_unmasked = |(status_q & ~mask_q);

    always_comb begin
        alarm_sum_d = any_unmasked;
        irq_d = |(status_q & irq_en_q);
        pin_d = cfg_q[CFG_PIN_ALARM] ? any_unmasked : i_cal_status;
        ser_pd_d = !cfg_d[CFG_LINK_EN];
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= STATUS_RESET;
            mask_q <= MASK_RESET;
            irq_en_q <= IRQ_EN_RESET;
            cfg_q <= CONFIG_RESET;
            alarm_sum_q <= 1'b0;
            irq_q <= 1'b0;
            pin_q <= 1'b0;
            ser_pd_q <= 1'b1;
        end else begin
            status_q <= status_d;
            mask_q <= mask_d;
            irq_en_q <= irq_en_d;
            cfg_q <= cfg_d;
            alarm_sum_q <= alarm_sum_d;
            irq_q <= irq_d;
            pin_q <= pin_d;
            ser_pd_q <= ser_pd_d;
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_irq = irq_q;
    assign o_status_output_pin = pin_q;
    // link reset, power-down and clock gate all follow the enable flop
    assign o_serial_link_enable = cfg_q[CFG_LINK_EN];
    assign o_link_rst_n = cfg_q[CFG_LINK_EN];
    assign o_link_clock_en = cfg_q[CFG_LINK_EN];
    assign o_serializer_pd = ser_pd_q;
    assign o_channel_a_powerdown = cfg_q[CFG_PD_A];
    assign o_channel_b_powerdown = cfg_q[CFG_PD_B];

    // ---- checks
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_mismatch;
        cfg_q[CFG_LINK_EN] && !cfg_q[CFG_PD_A] && !cfg_q[CFG_PD_B] && (i_clocks_a != i_clocks_b);
    endsequence

    sequence s_flag_up;
        ##1 status_q[ALM_CLOCK_UPSET];
    endsequence

    property p_pll_alarm;
        (cfg_q[CFG_LINK_EN] && !i_pll_locked) |=> status_q[ALM_PLL_UNLOCK];
    endproperty
    a_pll_alarm: assert property (p_pll_alarm) else $error("pll unlock not latched");

    property p_event_sets;
        (events != '0) |=> ((status_q & $past(events)) == $past(events));
    endproperty
    a_event_sets: assert property (p_event_sets) else $error("event did not set its bit");

    property p_sticky;
        1'b1 |=> ((status_q & $past(kept)) == $past(kept));
    endproperty
    a_sticky: assert property (p_sticky) else $error("status bit dropped without a clear");

    property p_summary;
        1'b1 |=> (alarm_sum_q == $past(any_unmasked));
    endproperty
    a_summary: assert property (p_summary) else $error("summary does not follow unmasked status");

    property p_pin_alarm;
        (cfg_q[CFG_PIN_ALARM] && any_unmasked) |=> o_status_output_pin;
    endproperty
    a_pin_alarm: assert property (p_pin_alarm) else $error("alarm pin stayed low");

    property p_upset_path;
        s_mismatch |=> s_flag_up;
    endproperty
    a_upset_path: assert property (p_upset_path) else $error("clock upset flag not set");

    property p_set_wins;
        (events[ALM_CLOCK_UPSET] && clr[ALM_CLOCK_UPSET]) |=> status_q[ALM_CLOCK_UPSET];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat a new clock upset");

    property p_link_off;
        !cfg_q[CFG_LINK_EN] |-> (o_serializer_pd && !o_link_clock_en && !o_link_rst_n);
    endproperty
    a_link_off: assert property (p_link_off) else $error("link section active while disabled");

    // upset flop lags the enable by one edge, so it is judged one cycle on
    property p_compare_off;
        !cfg_q[CFG_LINK_EN] |=> !upset_bus.upset;
    endproperty
    a_compare_off: assert property (p_compare_off) else $error("clock compare active while link disabled");

    property p_apb_answer;
        (i_psel && i_penable && !o_pready) |=> o_pready ##1 !o_pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb answer not one cycle after access");

    property p_link_alarm;
        (cfg_q[CFG_LINK_EN] && !i_link_in_data) |=> status_q[ALM_LINK_IDLE];
    endproperty
    a_link_alarm: assert property (p_link_alarm) else $error("link idle not latched");

    property p_sysref_alarm;
        i_sysref_realign |=> status_q[ALM_SYSREF_REALIGN];
    endproperty
    a_sysref_alarm: assert property (p_sysref_alarm) else $error("sysref realign not latched");

    property p_upset_alarm;
        upset_bus.upset |=> status_q[ALM_CLOCK_UPSET];
    endproperty
    a_upset_alarm: assert property (p_upset_alarm) else $error("clock upset not latched");

    property p_clear_works;
        (clr != '0) |=> ((status_q & $past(clr) & ~$past(events)) == '0);
    endproperty
    a_clear_works: assert property (p_clear_works) else $error("status bit survived its clear");

    property p_no_spurious_set;
        1'b1 |=> ((status_q & ~$past(status_q) & ~$past(events)) == '0);
    endproperty
    a_no_spurious_set: assert property (p_no_spurious_set) else $error("status bit rose without event");

    property p_zero_write_keeps;
        (wr_commit && (i_pwdata[ALARM_N-1:0] == '0)) |=> (status_q == ($past(status_q) | $past(events)));
    endproperty
    a_zero_write_keeps: assert property (p_zero_write_keeps) else $error("zero write changed status");

    property p_irq_level;
        1'b1 |=> (o_irq == |($past(status_q) & $past(irq_en_q)));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt does not follow enabled status");

    property p_pin_cal;
        !cfg_q[CFG_PIN_ALARM] |=> (o_status_output_pin == $past(i_cal_status));
    endproperty
    a_pin_cal: assert property (p_pin_cal) else $error("pin does not carry calibration status");

    property p_pin_quiet;
        (cfg_q[CFG_PIN_ALARM] && !any_unmasked) |=> !o_status_output_pin;
    endproperty
    a_pin_quiet: assert property (p_pin_quiet) else $error("alarm pin high with no unmasked alarm");

    property p_apb_error;
        (i_psel && i_penable && !o_pready) |=> (o_pslverr == !$past(mapped));
    endproperty
    a_apb_error: assert property (p_apb_error) else $error("apb error does not match address map");

    property p_write_lands;
        (wr_commit && addr_is(i_paddr, OFS_MASK)) |=> (mask_q == $past(i_pwdata[ALARM_N-1:0]));
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("mask write did not land");

    property p_serializer_pd;
        1'b1 |-> (o_serializer_pd == !cfg_q[CFG_LINK_EN]);
    endproperty
    a_serializer_pd: assert property (p_serializer_pd) else $error("serializer power-down off the enable");
endmodule

// >>> testbench/tb_top.sv
// self-checking bench for the alarm and clock upset monitor
module tb_top import alarm_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clock = 0, i_nrst = 0, psel = 0, penable = 0, pwrite = 0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [DATA_W-1:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, pll = 1, indata = 1, sysref = 0, cal = 0;
    logic [3:0] ca = 4'h3, cb = 4'h3;
    logic irq, pin, link_en, link_rst_n, ser_pd, clk_en, pd_a, pd_b;
    int n_fail = 0, check_count = 0;

    alarm_monitor #(.CLOCK_W(4)) i_dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_pll_locked(pll), .i_link_in_data(indata),
        .i_sysref_realign(sysref), .i_clocks_a(ca), .i_clocks_b(cb), .i_cal_status(cal), .o_irq(irq),
        .o_status_output_pin(pin), .o_serial_link_enable(link_en), .o_link_rst_n(link_rst_n),
        .o_serializer_pd(ser_pd), .o_link_clock_en(clk_en), .o_channel_a_powerdown(pd_a),
        .o_channel_b_powerdown(pd_b));

    initial begin
        forever #25 i_clock = ~i_clock;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // bus cycle; request held until pready is seen high at a rising edge, answer taken at that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        @(posedge i_clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        @(posedge i_clock);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge i_clock);
            n++;
        end
        if (n >= 20) chk("pready wait", 1, 0);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string name);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(name, exp, r);
        chk({name, " err"}, 0, {31'h0, e});
    endtask

    task automatic settle();
        repeat (4) @(posedge i_clock);
        @(negedge i_clock);
    endtask

    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rchk(OFS_STATUS, 32'h0, "status rst");
        rchk(OFS_MASK, 32'h0, "mask rst");
        rchk(OFS_IRQ_EN, 32'h0, "irq_en rst");
        rchk(OFS_CONFIG, 32'h0, "config rst");
        rchk(OFS_SUMMARY, 32'h0, "summary rst");
        chk("ser_pd off", 1, ser_pd);
        chk("link rst", 0, {link_rst_n, clk_en, link_en});
        apb(1'b0, 8'h18, 32'h0, r, e);
        chk("unmapped err", 1, e);
        chk("unmapped data", 0, r);
        $display("test reset done");
    endtask

    task automatic t_sysref();
        pll <= 1'b0;
        @(posedge i_clock);
        sysref <= 1'b1;
        @(posedge i_clock);
        sysref <= 1'b0;
        settle();
        rchk(OFS_STATUS, 32'h4, "sysref set");
        rchk(OFS_SUMMARY, 32'h1, "summary on");
        wr(OFS_STATUS, 32'h0);
        rchk(OFS_STATUS, 32'h4, "write zero kept");
        wr(OFS_MASK, 32'h4);
        settle();
        rchk(OFS_SUMMARY, 32'h0, "summary masked");
        wr(OFS_MASK, 32'h0);
        wr(OFS_IRQ_EN, 32'h4);
        settle();
        chk("irq high", 1, irq);
        wr(OFS_CLEAR, 32'h4);
        settle();
        rchk(OFS_STATUS, 32'h0, "sysref cleared");
        chk("irq low", 0, irq);
        pll <= 1'b1;
        $display("test sysref done");
    endtask

    task automatic t_link();
        pll <= 1'b0;
        indata <= 1'b0;
        wr(OFS_CONFIG, 32'h3);
        settle();
        chk("link on", 3'h7, {link_rst_n, clk_en, link_en});
        chk("ser_pd on", 0, ser_pd);
        rchk(OFS_STATUS, 32'h3, "pll and link");
        chk("pin alarm", 1, pin);
        pll <= 1'b1;
        indata <= 1'b1;
        settle();
        rchk(OFS_STATUS, 32'h3, "sticky");
        wr(OFS_STATUS, 32'h3);
        settle();
        rchk(OFS_STATUS, 32'h0, "cleared");
        chk("pin idle", 0, pin);
        cal <= 1'b1;
        wr(OFS_CONFIG, 32'h1);
        settle();
        chk("pin cal", 1, pin);
        @(posedge i_clock);
        cal <= 1'b0;
        $display("test link done");
    endtask

    task automatic t_upset();
        wr(OFS_CONFIG, 32'h0);
        wr(OFS_CONFIG, 32'h1);
        wr(OFS_CLEAR, 32'hF);
        @(posedge i_clock);
        cb <= 4'hC;
        @(posedge i_clock);
        cb <= 4'h3;
        settle();
        rchk(OFS_STATUS, 32'h8, "upset set");
        settle();
        rchk(OFS_STATUS, 32'h8, "upset held");
        // upset flop pulses in the very cycle the clear lands
        fork
            wr(OFS_STATUS, 32'h8);
            begin
                repeat (2) @(posedge i_clock);
                cb <= 4'hC;
                @(posedge i_clock);
                cb <= 4'h3;
            end
        join
        rchk(OFS_STATUS, 32'h8, "set beats clear");
        wr(OFS_STATUS, 32'h8);
        rchk(OFS_STATUS, 32'h0, "upset cleared");
        wr(OFS_CONFIG, 32'h5);
        settle();
        chk("pd a", 2'h2, {pd_a, pd_b});
        @(posedge i_clock);
        cb <= 4'hC;
        @(posedge i_clock);
        cb <= 4'h3;
        settle();
        rchk(OFS_STATUS, 32'h0, "upset one channel off");
        wr(OFS_CONFIG, 32'h0);
        $display("test upset done");
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge i_clock);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_clock);
        t_reset();
        t_sysref();
        t_link();
        t_upset();
        end_of_test();
    end

    // whole run needs well under 1000 cycles
    initial begin
        #250000;
        n_fail++;
        end_of_test();
    end
endmodule
